// ===== hdl/atc_override_bank.sv
// agc attack and decay time override registers with effective times
`timescale 1ns/100ps
`include "atc_regs.svh"
// Functional notes
// - left decay select picks legacy or override
// - left decay baseline 50/150/250/350 ms
// - decay multiplier is two to the code
// - attack multiplier is two to the code
// - right attack select picks legacy or override
// - right attack baseline 7/8/10/11 ms
// - right decay select picks legacy or override
// - right decay baseline 50/150/250/350 ms
// - decay cap 4/5.6/8/9.6 s low ratios
// - decay cap 11.2/16/19.2/22.4 s higher ratios
// - left attack select picks legacy or override
// - left attack baseline 7/8/10/11 ms scaled
module atc_override_bank #(
  parameter int TIME_W = 16 // width of time outputs in ms
) (
  input wire logic clk_i, // codec clock
  input wire logic rst_n_i, // async reset, active low
  input wire logic wr_i, // control bus write strobe
  input wire logic rd_i, // control bus read strobe
  input wire logic [6:0] addr_i, // register address
  input wire logic [7:0] wdata_i, // write data
  output logic [7:0] rdata_o, // read data, one cycle after rd_i
  input wire logic [3:0] adc_decimation_ratio_i, // 2*ratio-2
  input wire logic [15:0] l_att_legacy_ms_i, // left attack, legacy
  input wire logic [15:0] l_dec_legacy_ms_i, // left decay, legacy
  input wire logic [15:0] r_att_legacy_ms_i, // right attack, legacy
  input wire logic [15:0] r_dec_legacy_ms_i, // right decay, legacy
  output logic [15:0] l_att_ms_o, // left attack effective
  output logic [15:0] l_dec_ms_o, // left decay effective
  output logic [15:0] r_att_ms_o, // right attack effective
  output logic [15:0] r_dec_ms_o // right decay effective
);

  // ----------------------------------------------------------------
  // elaboration check
  // ----------------------------------------------------------------
  // the longest product, 350 ms times 128, needs all 16 bits
  if (TIME_W != 16) begin : g_bad_width
    $error("atc_override_bank: TIME_W must be 16");
  end

  // ----------------------------------------------------------------
  // decode
  // ----------------------------------------------------------------
  atc_pkg::atc_ovr_t latt_q, ldec_q, ratt_q, rdec_q; // override regs
  wire logic hit_latt; // address matches left attack
  wire logic hit_ldec; // address matches left decay
  wire logic hit_ratt; // address matches right attack
  wire logic hit_rdec; // address matches right decay
  wire logic [7:0] rdata_d; // read mux
  wire logic [15:0] cap_ms; // decay cap for current ratio

  assign hit_latt = addr_i == `ATC_LATT_OFS;
  assign hit_ldec = addr_i == `ATC_LDEC_OFS;
  assign hit_ratt = addr_i == `ATC_RATT_OFS;
  assign hit_rdec = addr_i == `ATC_RDEC_OFS;
  // unmapped addresses read as zero
  assign rdata_d = hit_latt ? latt_q :
                   hit_ldec ? ldec_q :
                   hit_ratt ? ratt_q :
                   hit_rdec ? rdec_q : 8'h00;

  // cap per decimation ratio; codes past 8 take the top cap
  function automatic logic [15:0] decay_cap(input logic [3:0] code);
    logic [15:0] c;
    c = `ATC_CAP_R5_X;
    case (code)
      4'h0: c = `ATC_CAP_R1_0;
      4'h1: c = `ATC_CAP_R1_5;
      4'h2: c = `ATC_CAP_R2_0;
      4'h3: c = `ATC_CAP_R2_5;
      4'h4, 4'h5: c = `ATC_CAP_R3_X;
      4'h6, 4'h7: c = `ATC_CAP_R4_X;
      4'h8: c = `ATC_CAP_R5_0;
      default: c = `ATC_CAP_R5_X;
    endcase
    return c;
  endfunction

  assign cap_ms = decay_cap(adc_decimation_ratio_i);

  // ----------------------------------------------------------------
  // register file
  // ----------------------------------------------------------------
  // reserved bits are stored as written; software keeps them zero
  // and only the read mux returns them
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      latt_q <= `ATC_REG_RST;
      ldec_q <= `ATC_REG_RST;
      ratt_q <= `ATC_REG_RST;
      rdec_q <= `ATC_REG_RST;
    end else if (wr_i) begin
      if (hit_latt) latt_q <= wdata_i;
      if (hit_ldec) ldec_q <= wdata_i;
      if (hit_ratt) ratt_q <= wdata_i;
      if (hit_rdec) rdec_q <= wdata_i;
    end
  end

  // read data holds its value between reads
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      rdata_o <= 8'h00;
    end else if (rd_i) begin
      rdata_o <= rdata_d;
    end
  end

  // ----------------------------------------------------------------
  // effective time constants
  // ----------------------------------------------------------------
  // left attack
  atc_time_calc #(.IS_DECAY(1'b0)) u_latt (
    .clk_i(clk_i), .rst_n_i(rst_n_i), .ovr_i(latt_q),
    .legacy_ms_i(l_att_legacy_ms_i), .cap_ms_i(cap_ms),
    .time_ms_o(l_att_ms_o));
  // left decay
  atc_time_calc #(.IS_DECAY(1'b1)) u_ldec (
    .clk_i(clk_i), .rst_n_i(rst_n_i), .ovr_i(ldec_q),
    .legacy_ms_i(l_dec_legacy_ms_i), .cap_ms_i(cap_ms),
    .time_ms_o(l_dec_ms_o));
  // right attack
  atc_time_calc #(.IS_DECAY(1'b0)) u_ratt (
    .clk_i(clk_i), .rst_n_i(rst_n_i), .ovr_i(ratt_q),
    .legacy_ms_i(r_att_legacy_ms_i), .cap_ms_i(cap_ms),
    .time_ms_o(r_att_ms_o));
  // right decay
  atc_time_calc #(.IS_DECAY(1'b1)) u_rdec (
    .clk_i(clk_i), .rst_n_i(rst_n_i), .ovr_i(rdec_q),
    .legacy_ms_i(r_dec_legacy_ms_i), .cap_ms_i(cap_ms),
    .time_ms_o(r_dec_ms_o));

  // ----------------------------------------------------------------
  // assertions
  // ----------------------------------------------------------------
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (!rst_n_i);

  // write of right decay with select set, then two quiet cycles
  sequence s_wr_rdec_ovr;
    wr_i && hit_rdec && wdata_i[`ATC_SEL_BIT];
  endsequence
  sequence s_rdec_quiet;
    !(wr_i && hit_rdec) [*2];
  endsequence

  chk_rdec_write_ovr: assert property (
    s_wr_rdec_ovr ##1 s_rdec_quiet |->
      r_dec_ms_o == ((atc_pkg::atc_scaled_ms(1'b1, rdec_q) >
                      $past(cap_ms)) ? $past(cap_ms)
                     : atc_pkg::atc_scaled_ms(1'b1, rdec_q)))
    else $error("right decay override not applied");

  chk_ldec_legacy_pass: assert property (
    !ldec_q.sel |=> l_dec_ms_o == $past(l_dec_legacy_ms_i))
    else $error("left decay legacy not passed");

  chk_ratt_legacy_pass: assert property (
    !ratt_q.sel |=> r_att_ms_o == $past(r_att_legacy_ms_i))
    else $error("right attack legacy not passed");

  chk_latt_ovr_value: assert property (
    latt_q.sel && latt_q.base == 2'h3 && latt_q.mult == 3'h7 |=>
      l_att_ms_o == 16'h0580)
    else $error("left attack 11 ms x 128 wrong");

  chk_ratt_ovr_value: assert property (
    ratt_q.sel |=> r_att_ms_o ==
      ($past(atc_pkg::atc_base_ms(1'b0, ratt_q.base)) <<
       $past(ratt_q.mult)))
    else $error("right attack override wrong");

  chk_ldec_cap_limit: assert property (
    ldec_q.sel |=> l_dec_ms_o <= $past(cap_ms))
    else $error("left decay above cap");

  chk_ldec_min_value: assert property (
    ldec_q.sel && ldec_q.base == 2'h0 && ldec_q.mult == 3'h0 |=>
      l_dec_ms_o == 16'h0032)
    else $error("left decay 50 ms wrong");

  chk_cap_ratio_six: assert property (
    adc_decimation_ratio_i == 4'hA |-> cap_ms == 16'h5780)
    else $error("cap for ratio 6 wrong");

  chk_read_back: assert property (
    rd_i && !wr_i |=> rdata_o == $past(rdata_d))
    else $error("read data mismatch");

  // a write lands in the addressed register at its own edge
  chk_ldec_write_lands: assert property (
    wr_i && hit_ldec |=> ldec_q == $past(wdata_i))
    else $error("left decay write lost");

  chk_latt_legacy_pass: assert property (
    !latt_q.sel |=> l_att_ms_o == $past(l_att_legacy_ms_i))
    else $error("left attack legacy not passed");

  chk_rdec_legacy_pass: assert property (
    !rdec_q.sel |=> r_dec_ms_o == $past(r_dec_legacy_ms_i))
    else $error("right decay legacy not passed");

  chk_rdec_cap_limit: assert property (
    rdec_q.sel |=> r_dec_ms_o <= $past(cap_ms))
    else $error("right decay above cap");

  // 7 ms times 128, the top attack factor
  chk_ratt_max_factor: assert property (
    ratt_q.sel && ratt_q.base == 2'h0 && ratt_q.mult == 3'h7 |=>
      r_att_ms_o == 16'h0380)
    else $error("right attack 7 ms x 128 wrong");

  // 350 ms sits below every cap, so it must pass unclipped
  chk_rdec_top_base: assert property (
    rdec_q.sel && rdec_q.base == 2'h3 && rdec_q.mult == 3'h0 |=>
      r_dec_ms_o == 16'h015E)
    else $error("right decay 350 ms wrong");

  chk_cap_ratio_one: assert property (
    adc_decimation_ratio_i == 4'h0 |-> cap_ms == 16'h0FA0)
    else $error("cap for ratio 1 wrong");

endmodule

// ===== hdl/atc_time_calc.sv
// one effective agc time constant: legacy or override, capped for decay
`timescale 1ns/100ps
module atc_time_calc #(
  parameter bit IS_DECAY = 1'b0 // 1: decay path with cap
) (
  input wire logic clk_i, // codec clock
  input wire logic rst_n_i, // async reset, active low
  input wire atc_pkg::atc_ovr_t ovr_i, // override register
  input wire logic [15:0] legacy_ms_i, // time from legacy agc reg
  input wire logic [15:0] cap_ms_i, // decay cap for current ratio
  output logic [15:0] time_ms_o // effective time, registered
);

  // ----------------------------------------------------------------
  // selection
  // ----------------------------------------------------------------
  wire logic [15:0] scaled_ms; // baseline times factor
  wire logic [15:0] ovr_ms; // override after cap
  wire logic [15:0] time_ms_d; // next effective time

  // multiplier code shifts the baseline left
  assign scaled_ms = atc_pkg::atc_scaled_ms(IS_DECAY, ovr_i);
  // cap only bites on decay; attack never reaches a cap
  assign ovr_ms = (IS_DECAY && scaled_ms > cap_ms_i) ? cap_ms_i
                                                     : scaled_ms;
  // legacy time passes untouched when select is clear
  assign time_ms_d = ovr_i.sel ? ovr_ms : legacy_ms_i;

  // ----------------------------------------------------------------
  // output register
  // ----------------------------------------------------------------
  // register keeps the output glitch free toward the gain loop
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      time_ms_q_reset: time_ms_o <= 16'h0000;
    end else begin
      time_ms_o <= time_ms_d;
    end
  end

endmodule

// ===== pkg/atc_pkg.sv
// types and shared lookups of the agc time constant override bank
`include "atc_regs.svh"
package atc_pkg;

  // ----------------------------------------------------------------
  // one override register, msb first
  // ----------------------------------------------------------------
  typedef struct packed {
    logic sel; // 1: use this register, 0: legacy
    logic [1:0] base; // baseline code
    logic [2:0] mult; // power of two exponent
    logic [1:0] rsvd; // reserved, stored as written
  } atc_ovr_t;

  // baseline in ms for attack or decay
  function automatic logic [15:0] atc_base_ms(input logic is_dec,
                                             input logic [1:0] code);
    logic [15:0] ms;
    ms = 16'h0000;
    case (code)
      2'h0: ms = is_dec ? `ATC_DEC_MS0 : `ATC_ATT_MS0;
      2'h1: ms = is_dec ? `ATC_DEC_MS1 : `ATC_ATT_MS1;
      2'h2: ms = is_dec ? `ATC_DEC_MS2 : `ATC_ATT_MS2;
      default: ms = is_dec ? `ATC_DEC_MS3 : `ATC_ATT_MS3;
    endcase
    return ms;
  endfunction

  // baseline scaled by 2**mult; 350 * 128 still fits 16 bits
  function automatic logic [15:0] atc_scaled_ms(input logic is_dec,
                                               input atc_ovr_t r);
    return atc_base_ms(is_dec, r.base) << r.mult;
  endfunction

endpackage

// ===== pkg/atc_regs.svh
// register offsets, field positions, reset values and time figures
`ifndef ATC_REGS_SVH
`define ATC_REGS_SVH

// ----------------------------------------------------------------
// register offsets (7-bit control bus address)
// ----------------------------------------------------------------
`define ATC_LATT_OFS 7'h67
`define ATC_LDEC_OFS 7'h68
`define ATC_RATT_OFS 7'h69
`define ATC_RDEC_OFS 7'h6A

// ----------------------------------------------------------------
// field positions and reset value
// ----------------------------------------------------------------
`define ATC_SEL_BIT 7
`define ATC_BASE_MSB 6
`define ATC_BASE_LSB 5
`define ATC_MULT_MSB 4
`define ATC_MULT_LSB 2
`define ATC_REG_RST 8'h00

// ----------------------------------------------------------------
// baseline times in ms
// ----------------------------------------------------------------
`define ATC_ATT_MS0 16'h0007
`define ATC_ATT_MS1 16'h0008
`define ATC_ATT_MS2 16'h000A
`define ATC_ATT_MS3 16'h000B
`define ATC_DEC_MS0 16'h0032
`define ATC_DEC_MS1 16'h0096
`define ATC_DEC_MS2 16'h00FA
`define ATC_DEC_MS3 16'h015E

// ----------------------------------------------------------------
// decay caps in ms, ratio code = 2 * ratio - 2
// ----------------------------------------------------------------
`define ATC_CAP_R1_0 16'h0FA0
`define ATC_CAP_R1_5 16'h15E0
`define ATC_CAP_R2_0 16'h1F40
`define ATC_CAP_R2_5 16'h2580
`define ATC_CAP_R3_X 16'h2BC0
`define ATC_CAP_R4_X 16'h3E80
`define ATC_CAP_R5_0 16'h4B00
`define ATC_CAP_R5_X 16'h5780

`endif

// ===== testbench/tb.sv
// self-checking bench of the agc time constant override bank
`timescale 1ns/100ps
`include "atc_regs.svh"
module tb;
  // ----------------------------------------------------------------
  // stimulus and observed signals
  // ----------------------------------------------------------------
  logic clk_i = 1'b0; // codec clock
  logic rst_n_i = 1'b0; // reset, active low
  logic wr_i = 1'b0; // write strobe
  logic rd_i = 1'b0; // read strobe
  logic [6:0] addr_i = 7'h00; // register address
  logic [7:0] wdata_i = 8'h00; // write data
  logic [3:0] ratio = 4'hA; // decimation ratio code
  logic [7:0] rdata_o; // read data
  logic [15:0] leg [4] = '{16'h1111, 16'h2222, 16'h3333, 16'h4444};
  logic [15:0] l_att_ms_o; // left attack out
  logic [15:0] l_dec_ms_o; // left decay out
  logic [15:0] r_att_ms_o; // right attack out
  logic [15:0] r_dec_ms_o; // right decay out
  int mismatches = 0; // failed compares
  int check_count = 0; // all compares
  // expected tables, in ms
  logic [15:0] att_tab [4] = '{16'h0007, 16'h0008, 16'h000A, 16'h000B};
  logic [15:0] dec_tab [4] = '{16'h0032, 16'h0096, 16'h00FA, 16'h015E};
  logic [15:0] cap_tab [11] = '{16'h0FA0, 16'h15E0, 16'h1F40, 16'h2580,
    16'h2BC0, 16'h2BC0, 16'h3E80, 16'h3E80, 16'h4B00, 16'h5780, 16'h5780};

  // 4 ns period
  always #2 clk_i = ~clk_i;

  atc_override_bank uut (
    .clk_i(clk_i), .rst_n_i(rst_n_i), .wr_i(wr_i), .rd_i(rd_i),
    .addr_i(addr_i), .wdata_i(wdata_i), .rdata_o(rdata_o),
    .adc_decimation_ratio_i(ratio), .l_att_legacy_ms_i(leg[0]),
    .l_dec_legacy_ms_i(leg[1]), .r_att_legacy_ms_i(leg[2]),
    .r_dec_legacy_ms_i(leg[3]), .l_att_ms_o(l_att_ms_o),
    .l_dec_ms_o(l_dec_ms_o), .r_att_ms_o(r_att_ms_o),
    .r_dec_ms_o(r_dec_ms_o)
  );

  // ----------------------------------------------------------------
  // shared tasks
  // ----------------------------------------------------------------
  task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
    check_count++;
    if (seen !== exp) begin
      mismatches++;
      $display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask

  // one write cycle; reserved bits d1-d0 always sent as zero
  task automatic wr(input logic [6:0] a, input logic [7:0] d);
    @(negedge clk_i);
    wr_i = 1'b1;
    addr_i = a;
    wdata_i = {d[7:2], 2'b00};
    @(negedge clk_i);
    wr_i = 1'b0;
    @(negedge clk_i); // time outputs follow one edge later
  endtask

  task automatic rd(input logic [6:0] a, input logic [7:0] e);
    @(negedge clk_i);
    rd_i = 1'b1;
    addr_i = a;
    @(negedge clk_i);
    rd_i = 1'b0;
    chk({8'h00, rdata_o}, {8'h00, e});
  endtask

  // decay expectation, clipped by the current ratio cap
  function automatic logic [15:0] dec_exp(input int b, input int m);
    logic [15:0] v;
    v = dec_tab[b] << m;
    return (v > cap_tab[ratio]) ? cap_tab[ratio] : v;
  endfunction

  // ----------------------------------------------------------------
  // scenarios
  // ----------------------------------------------------------------
  task automatic t_reset();
    rd(`ATC_LATT_OFS, 8'h00);
    rd(`ATC_LDEC_OFS, 8'h00);
    rd(`ATC_RATT_OFS, 8'h00);
    rd(`ATC_RDEC_OFS, 8'h00);
    chk(l_att_ms_o, leg[0]);
    chk(l_dec_ms_o, leg[1]);
    chk(r_att_ms_o, leg[2]);
    chk(r_dec_ms_o, leg[3]);
    wr(7'h70, 8'hFC); // unmapped place ignores writes
    rd(7'h70, 8'h00);
    $display("test reset done");
  endtask

  // every baseline and factor of the left decay, at the widest cap
  task automatic t_left_decay();
    for (int b = 0; b < 4; b++) begin
      for (int m = 0; m < 8; m++) begin
        wr(`ATC_LDEC_OFS, {1'b1, b[1:0], m[2:0], 2'b00});
        chk(l_dec_ms_o, dec_exp(b, m));
        chk(r_dec_ms_o, leg[3]);
      end
    end
    rd(`ATC_LDEC_OFS, 8'hFC);
    $display("test left decay done");
  endtask

  // both attack registers swept together
  task automatic t_attack();
    for (int b = 0; b < 4; b++) begin
      for (int m = 0; m < 8; m++) begin
        wr(`ATC_LATT_OFS, {1'b1, b[1:0], m[2:0], 2'b00});
        wr(`ATC_RATT_OFS, {1'b1, 2'(3 - b), m[2:0], 2'b00});
        chk(l_att_ms_o, att_tab[b] << m);
        chk(r_att_ms_o, att_tab[3 - b] << m);
      end
    end
    rd(`ATC_RATT_OFS, 8'h9C);
    $display("test attack done");
  endtask

  // right decay baselines under the smallest cap, then every cap
  task automatic t_right_decay();
    ratio = 4'h0;
    for (int b = 0; b < 4; b++) begin
      wr(`ATC_RDEC_OFS, {1'b1, b[1:0], 3'h0, 2'b00});
      chk(r_dec_ms_o, dec_tab[b]);
    end
    wr(`ATC_RDEC_OFS, 8'hFC);
    for (int r = 0; r < 11; r++) begin
      @(negedge clk_i);
      ratio = r[3:0];
      @(negedge clk_i);
      @(negedge clk_i);
      chk(r_dec_ms_o, cap_tab[r]);
      chk(l_dec_ms_o, dec_exp(3, 7));
    end
    @(negedge clk_i);
    ratio = 4'hF; // codes past eight keep the top cap
    @(negedge clk_i);
    chk(r_dec_ms_o, cap_tab[10]);
    $display("test right decay done");
  endtask

  // clearing the select bits hands all four back to legacy
  task automatic t_back_to_legacy();
    ratio = 4'h0; // smallest cap: legacy decay must stay unclipped
    wr(`ATC_LATT_OFS, 8'h7C);
    wr(`ATC_LDEC_OFS, 8'h7C);
    wr(`ATC_RATT_OFS, 8'h7C);
    wr(`ATC_RDEC_OFS, 8'h7C);
    chk(l_att_ms_o, leg[0]);
    chk(l_dec_ms_o, leg[1]);
    chk(r_att_ms_o, leg[2]);
    chk(r_dec_ms_o, leg[3]);
    rd(`ATC_RDEC_OFS, 8'h7C);
    $display("test back to legacy done");
  endtask

  // reset in mid-run clears the bank and hands back to legacy
  task automatic t_mid_reset();
    wr(`ATC_LDEC_OFS, 8'hFC);
    @(negedge clk_i);
    rst_n_i = 1'b0;
    @(negedge clk_i);
    chk(l_dec_ms_o, 16'h0000);
    rst_n_i = 1'b1;
    rd(`ATC_LDEC_OFS, 8'h00);
    chk(l_dec_ms_o, leg[1]);
    $display("test mid reset done");
  endtask

  // ----------------------------------------------------------------
  // run control
  // ----------------------------------------------------------------
  task automatic stop_test();
    $display("checks %0d mismatches %0d", check_count, mismatches);
    if (mismatches == 0 && check_count > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask

  // main sequence: reset held ten cycles, released off the edge
  initial begin
    repeat (10) @(negedge clk_i);
    rst_n_i = 1'b1;
    t_reset();
    t_left_decay();
    t_attack();
    t_right_decay();
    t_back_to_legacy();
    t_mid_reset();
    stop_test();
  end

  // watchdog: the run needs well under a thousand cycles
  initial begin
    #40000;
    mismatches++;
    stop_test();
  end
endmodule
